// *** src/flvic_controller.sv ***
`timescale 1ns/1ps
// What this block does
// (R01) External pins 0 and 1 each select edge or level trigger by own bit.
// (R02) Edge mode: pin sampled per machine cycle, high then low sets flag.
// (R03) Requester holds pin high then low one full machine cycle each.
// (R04) Edge-mode external 0 and 1 flags cleared by hardware when vectoring to them.
// (R05) Level-mode external flag not cleared on vectoring; tracks pin level.
// (R06) Level-mode source holds pin low until actually serviced.
// (R07) Software clears external 2 and 3 request flags itself.
// (R08) Timer 0/1 overflow flags request, cleared by hardware on vectoring.
// (R09) Timer 2 request is OR of its two flags; never hardware cleared.
// (R10) Serial request is OR of receive and transmit flags; software clears.
// (R11) Every request flag is software writable; a set flag requests normally.
// (R12) Per-source enables; global enable clear masks every source.
// (R13) Priority high and low bits form level 0 (lowest) to 3 (highest).
// (R14) Service preempted only by strictly higher level.
// (R15) Equal-level ties follow fixed ranking ext0 first, ext3 last.
// (R16) Flags sampled each machine cycle and resolved in that same cycle.
// (R17) Call needs: no equal-or-higher in service, last cycle, no blocking op.
// (R18) Denied requests are not remembered; each poll starts fresh.
// (R19) Call pushes PC, not status word, and loads the winner's vector.
// (R20) Only return-from-interrupt ends in-service; plain return does not.
// (R21) Pins sampled at fixed phase; timer flags polled in next machine cycle.
// (R22) Call spans four machine cycles; five cycles minimum latency.
// (R23) Machine cycle is 12 or 6 clock periods by configuration.
// (R24) One in-service bit per level; return clears highest; four deep nesting.
module flvic_controller
   import flvic_pkg::*;
(
   input  wire logic        ref_clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        ce_in,
   input  wire logic        hsel_in,
   input  wire logic [31:0] haddr_in,
   input  wire logic [1:0]  htrans_in,
   input  wire logic        hwrite_in,
   input  wire logic [2:0]  hsize_in,
   input  wire logic [31:0] hwdata_in,
   input  wire logic        hready_in,
   output logic      [31:0] hrdata_out,
   output logic             hreadyout_out,
   output logic             hresp_out,
   input  wire logic [3:0]  ext_irq_pin_n_in,
   input  wire flvic_evt_t  periph_evt_in,
   input  wire logic        cpu_last_cycle_in,
   input  wire logic        cpu_irq_block_in,
   input  wire logic        cpu_return_from_irq_in,
   output flvic_call_t      irq_call_out,
   output logic      [3:0]  in_service_out
);

   logic [7:0]  enable_reg;
   logic [7:0]  prio_high_reg;
   logic [7:0]  prio_low_reg;
   logic [7:0]  timer_ctl_reg;
   logic [7:0]  ext_ctl_reg;
   logic [7:0]  serial_reg;
   logic [7:0]  timer2_reg;
   logic [7:0]  config_reg;
   logic [3:0]  phase_reg;
   logic [3:0]  pin_smp_reg;
   logic [7:0]  req_snap_reg;
   logic [3:0]  isr_reg;
   logic [2:0]  busy_reg;
   logic [2:0]  last_src_reg;
   logic        reg_block_reg;
   logic        ap_valid_reg;
   logic        ap_write_reg;
   logic [7:0]  ap_addr_reg;
   logic        rd_wait_reg;
   logic [31:0] hrdata_reg;
   flvic_call_t call_reg;

   logic        six_mode;
   logic        mc_last;
   logic        pin_phase;
   logic [3:0]  pin_fall;
   logic        wr_en;
   logic [7:0]  wdata;
   logic [7:0]  req_raw;
   logic [7:0]  src_enable;
   logic [7:0]  prio_low_bits;
   logic        win_found;
   logic [2:0]  win_idx;
   logic [1:0]  win_lvl;
   logic        win_allowed;
   logic        call_fire;
   logic [7:0]  hw_clear;
   logic [3:0]  isr_top;
   logic [7:0]  rd_mux;

   assign six_mode  = config_reg[CFG_SIX_MODE];
   assign mc_last   = phase_reg == (six_mode ? MC_LAST_6T : MC_LAST_12T);    // see (R23)
   assign pin_phase = phase_reg == (six_mode ? PIN_PHASE_6T : PIN_PHASE_12T); // see (R21)
   assign pin_fall  = pin_smp_reg & ~ext_irq_pin_n_in;                      // see (R02)
   assign wr_en     = ap_valid_reg & ap_write_reg;
   assign wdata     = hwdata_in[7:0];
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         ap_valid_reg <= 1'b0;
         ap_write_reg <= 1'b0;
         ap_addr_reg  <= RST_BYTE;
      end
      else if (ce_in && hready_in)
      begin
         ap_valid_reg <= hsel_in & htrans_in[1];
         ap_write_reg <= hwrite_in;
         ap_addr_reg  <= haddr_in[7:0];
      end
   end

   // Reads take one wait state so read data comes from a flip-flop
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rd_wait_reg <= 1'b0;
         hrdata_reg  <= 32'h0000_0000;
      end
      else if (ce_in)
      begin
         if (rd_wait_reg)
         begin
            rd_wait_reg <= 1'b0;
            hrdata_reg  <= {24'h00_0000, rd_mux};
         end
         else if (hready_in)
         begin
            rd_wait_reg <= hsel_in & htrans_in[1] & ~hwrite_in;
         end
      end
   end
   always_comb
   begin
      case (ap_addr_reg)
         ADDR_ENABLE    : rd_mux = enable_reg;
         ADDR_PRIO_HIGH : rd_mux = prio_high_reg;
         ADDR_PRIO_LOW  : rd_mux = prio_low_reg;
         ADDR_TIMER_CTL : rd_mux = timer_ctl_reg;
         ADDR_EXT_CTL   : rd_mux = ext_ctl_reg;
         ADDR_SERIAL    : rd_mux = serial_reg;
         ADDR_TIMER2    : rd_mux = timer2_reg;
         ADDR_CONFIG    : rd_mux = config_reg;
         ADDR_STATUS    : rd_mux = {1'b0, last_src_reg, isr_reg};
         default        : rd_mux = RST_BYTE;
      endcase
   end

   assign hrdata_out    = hrdata_reg;
   assign hreadyout_out = ~rd_wait_reg;
   assign hresp_out     = 1'b0;
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         enable_reg    <= RST_BYTE;
         prio_high_reg <= RST_BYTE;
         prio_low_reg  <= RST_BYTE;
         config_reg    <= RST_BYTE;
      end
      else if (ce_in && wr_en)
      begin
         case (ap_addr_reg)
            ADDR_ENABLE    : enable_reg    <= wdata;
            ADDR_PRIO_HIGH : prio_high_reg <= wdata;
            ADDR_PRIO_LOW  : prio_low_reg  <= wdata;
            ADDR_CONFIG    : config_reg    <= wdata;
            default        : ;
         endcase
      end
   end
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         phase_reg <= 4'h0;
      else if (ce_in)
         phase_reg <= mc_last ? 4'h0 : phase_reg + 4'h1; // see (R23)
   end
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         pin_smp_reg <= 4'hF;
      else if (ce_in && pin_phase)
         pin_smp_reg <= ext_irq_pin_n_in; // see (R21)
   end
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         timer_ctl_reg <= RST_BYTE;
      else if (ce_in)
      begin
         if (wr_en && ap_addr_reg == ADDR_TIMER_CTL)
            timer_ctl_reg <= wdata; // see (R11)
         if (hw_clear[SRC_TIMER0])
            timer_ctl_reg[TC_TIMER0_FLAG] <= 1'b0; // see (R08)
         if (hw_clear[SRC_TIMER1])
            timer_ctl_reg[TC_TIMER1_FLAG] <= 1'b0; // see (R08)
         if (hw_clear[SRC_EXT0] && timer_ctl_reg[TC_EXT0_TRIG])
            timer_ctl_reg[TC_EXT0_FLAG] <= 1'b0; // see (R04)
         if (hw_clear[SRC_EXT1] && timer_ctl_reg[TC_EXT1_TRIG])
            timer_ctl_reg[TC_EXT1_FLAG] <= 1'b0; // see (R04)
         if (periph_evt_in.timer0_ovf)
            timer_ctl_reg[TC_TIMER0_FLAG] <= 1'b1;
         if (periph_evt_in.timer1_ovf)
            timer_ctl_reg[TC_TIMER1_FLAG] <= 1'b1;
         if (pin_phase)
         begin
            if (!timer_ctl_reg[TC_EXT0_TRIG])
               timer_ctl_reg[TC_EXT0_FLAG] <= ~ext_irq_pin_n_in[0]; // see (R05)
            else if (pin_fall[0])
               timer_ctl_reg[TC_EXT0_FLAG] <= 1'b1; // see (R01)
            if (!timer_ctl_reg[TC_EXT1_TRIG])
               timer_ctl_reg[TC_EXT1_FLAG] <= ~ext_irq_pin_n_in[1]; // see (R05)
            else if (pin_fall[1])
               timer_ctl_reg[TC_EXT1_FLAG] <= 1'b1; // see (R01)
         end
      end
   end
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         ext_ctl_reg <= RST_BYTE;
      else if (ce_in)
      begin
         if (wr_en && ap_addr_reg == ADDR_EXT_CTL)
            ext_ctl_reg <= wdata; // see (R07)
         if (pin_phase)
         begin
            if (!ext_ctl_reg[XC_EXT2_TRIG])
               ext_ctl_reg[XC_EXT2_FLAG] <= ~ext_irq_pin_n_in[2];
            else if (pin_fall[2])
               ext_ctl_reg[XC_EXT2_FLAG] <= 1'b1;
            if (!ext_ctl_reg[XC_EXT3_TRIG])
               ext_ctl_reg[XC_EXT3_FLAG] <= ~ext_irq_pin_n_in[3];
            else if (pin_fall[3])
               ext_ctl_reg[XC_EXT3_FLAG] <= 1'b1;
         end
      end
   end
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         serial_reg <= RST_BYTE;
         timer2_reg <= RST_BYTE;
      end
      else if (ce_in)
      begin
         if (wr_en && ap_addr_reg == ADDR_SERIAL)
            serial_reg <= wdata; // see (R10)
         if (wr_en && ap_addr_reg == ADDR_TIMER2)
            timer2_reg <= wdata; // see (R09)
         if (periph_evt_in.serial_rx)
            serial_reg[SC_RX_FLAG] <= 1'b1;
         if (periph_evt_in.serial_tx)
            serial_reg[SC_TX_FLAG] <= 1'b1;
         if (periph_evt_in.timer2_ovf)
            timer2_reg[T2_OVF_FLAG] <= 1'b1;
         if (periph_evt_in.timer2_cr)
            timer2_reg[T2_CR_FLAG] <= 1'b1;
      end
   end
   assign req_raw = {ext_ctl_reg[XC_EXT3_FLAG],
                     ext_ctl_reg[XC_EXT2_FLAG],
                     timer2_reg[T2_OVF_FLAG] | timer2_reg[T2_CR_FLAG], // see (R09)
                     serial_reg[SC_RX_FLAG] | serial_reg[SC_TX_FLAG],  // see (R10)
                     timer_ctl_reg[TC_TIMER1_FLAG],
                     timer_ctl_reg[TC_EXT1_FLAG],
                     timer_ctl_reg[TC_TIMER0_FLAG],
                     timer_ctl_reg[TC_EXT0_FLAG]};
   assign src_enable = {ext_ctl_reg[XC_EXT3_ENABLE], ext_ctl_reg[XC_EXT2_ENABLE],
                        enable_reg[5:0]} & {8{enable_reg[EN_GLOBAL]}}; // see (R12)
   assign prio_low_bits = {ext_ctl_reg[XC_EXT3_PRIO_LOW], ext_ctl_reg[XC_EXT2_PRIO_LOW],
                           prio_low_reg[5:0]};
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         req_snap_reg <= RST_BYTE;
      else if (ce_in && phase_reg == 4'h0)
         req_snap_reg <= req_raw; // see (R16) (R18) (R21)
   end
   always_comb
   begin
      win_found = 1'b0;
      win_idx   = 3'h0;
      win_lvl   = 2'h0;
      for (int i = 0; i < 8; i++)
      begin
         if (req_snap_reg[i] && src_enable[i] &&
             (!win_found || {prio_high_reg[i], prio_low_bits[i]} > win_lvl)) // see (R15)
         begin
            win_found = 1'b1;
            win_idx   = 3'(i);
            win_lvl   = {prio_high_reg[i], prio_low_bits[i]}; // see (R13)
         end
      end
   end

   assign win_allowed = (isr_reg & (4'hF << win_lvl)) == 4'h0; // see (R14)
   assign call_fire   = ce_in & mc_last & win_found & win_allowed & (busy_reg == 3'h0)
                      & cpu_last_cycle_in & ~cpu_irq_block_in & ~cpu_return_from_irq_in
                      & ~reg_block_reg; // see (R17)
   assign hw_clear    = call_fire ? (8'h01 << win_idx) : 8'h00;
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         reg_block_reg <= 1'b0;
      else if (ce_in)
      begin
         if (wr_en && (ap_addr_reg == ADDR_ENABLE || ap_addr_reg == ADDR_PRIO_HIGH ||
                       ap_addr_reg == ADDR_PRIO_LOW || ap_addr_reg == ADDR_EXT_CTL))
            reg_block_reg <= 1'b1; // see (R17)
         else if (mc_last)
            reg_block_reg <= 1'b0;
      end
   end
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         busy_reg <= 3'h0;
      else if (call_fire)
         busy_reg <= CALL_MC; // see (R22)
      else if (ce_in && mc_last && busy_reg != 3'h0)
         busy_reg <= busy_reg - 3'h1;
   end

   always_comb
   begin
      isr_top = 4'h0;
      for (int i = 0; i < 4; i++)
         if (isr_reg[i])
            isr_top = 4'h1 << i;
   end
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         isr_reg <= 4'h0;
      else if (call_fire)
         isr_reg <= isr_reg | (4'h1 << win_lvl); // see (R24)
      else if (ce_in && cpu_return_from_irq_in)
         isr_reg <= isr_reg & ~isr_top; // see (R20) (R24)
   end
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         call_reg     <= '0;
         last_src_reg <= 3'h0;
      end
      else if (ce_in)
      begin
         call_reg.call <= call_fire;
         if (call_fire)
         begin
            call_reg.level  <= win_lvl;
            call_reg.vector <= VECTOR_BASE + (16'(win_idx) << VECTOR_SHIFT); // see (R19)
            last_src_reg    <= win_idx;
         end
      end
   end

   assign irq_call_out   = call_reg;
   assign in_service_out = isr_reg;

endmodule : flvic_controller

// *** shared/flvic_pkg.sv ***
package flvic_pkg;

   // Register byte addresses
   localparam logic [7:0] ADDR_ENABLE    = 8'h00;
   localparam logic [7:0] ADDR_PRIO_HIGH = 8'h04;
   localparam logic [7:0] ADDR_PRIO_LOW  = 8'h08;
   localparam logic [7:0] ADDR_TIMER_CTL = 8'h0C;
   localparam logic [7:0] ADDR_EXT_CTL   = 8'h10;
   localparam logic [7:0] ADDR_SERIAL    = 8'h14;
   localparam logic [7:0] ADDR_TIMER2    = 8'h18;
   localparam logic [7:0] ADDR_CONFIG    = 8'h1C;
   localparam logic [7:0] ADDR_STATUS    = 8'h20;

   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;

   // Enable register fields
   localparam int EN_GLOBAL = 7;

   // Timer control register fields
   localparam int TC_TIMER1_FLAG = 7;
   localparam int TC_TIMER0_FLAG = 5;
   localparam int TC_EXT1_FLAG   = 3;
   localparam int TC_EXT1_TRIG   = 2;
   localparam int TC_EXT0_FLAG   = 1;
   localparam int TC_EXT0_TRIG   = 0;

   // External control register fields
   localparam int XC_EXT3_PRIO_LOW = 7;
   localparam int XC_EXT3_ENABLE   = 6;
   localparam int XC_EXT3_FLAG     = 5;
   localparam int XC_EXT3_TRIG     = 4;
   localparam int XC_EXT2_PRIO_LOW = 3;
   localparam int XC_EXT2_ENABLE   = 2;
   localparam int XC_EXT2_FLAG     = 1;
   localparam int XC_EXT2_TRIG     = 0;

   // Serial and timer 2 flag fields
   localparam int SC_RX_FLAG   = 0;
   localparam int SC_TX_FLAG   = 1;
   localparam int T2_OVF_FLAG  = 7;
   localparam int T2_CR_FLAG   = 6;
   localparam int CFG_SIX_MODE = 0;

   // Source indexes in arbitration order
   localparam logic [2:0] SRC_EXT0   = 3'h0;
   localparam logic [2:0] SRC_TIMER0 = 3'h1;
   localparam logic [2:0] SRC_EXT1   = 3'h2;
   localparam logic [2:0] SRC_TIMER1 = 3'h3;

   // Machine cycle timing in oscillator periods; call length in machine cycles
   localparam logic [3:0] MC_LAST_12T   = 4'hB;
   localparam logic [3:0] MC_LAST_6T    = 4'h5;
   localparam logic [3:0] PIN_PHASE_12T = 4'h9;
   localparam logic [3:0] PIN_PHASE_6T  = 4'h4;
   localparam logic [2:0] CALL_MC       = 3'h4;

   // Vector table
   localparam logic [15:0] VECTOR_BASE = 16'h0003;
   localparam int          VECTOR_SHIFT = 3;

   typedef struct packed {
      logic timer0_ovf;
      logic timer1_ovf;
      logic timer2_ovf;
      logic timer2_cr;
      logic serial_rx;
      logic serial_tx;
   } flvic_evt_t;

   typedef struct packed {
      logic        call;
      logic [1:0]  level;
      logic [15:0] vector;
   } flvic_call_t;

endpackage : flvic_pkg

// *** test/flvic_assertions.sv ***
`timescale 1ns/1ps
module flvic_assertions
   import flvic_pkg::*;
(
   input wire logic        ref_clk_in,
   input wire logic        rst_n_in,
   input wire logic        ce_in,
   input wire logic        hsel_in,
   input wire logic [1:0]  htrans_in,
   input wire logic        hwrite_in,
   input wire logic        hready_in,
   input wire logic        hreadyout_out,
   input wire logic        cpu_last_cycle_in,
   input wire logic        cpu_irq_block_in,
   input wire logic        cpu_return_from_irq_in,
   input wire flvic_call_t irq_call_out,
   input wire logic [3:0]  in_service_out
);
   logic [7:0]  gap_reg;
   logic        call;
   logic [3:0]  isr;
   logic [15:0] vec;
   assign call = irq_call_out.call;
   assign isr = in_service_out;
   assign vec = irq_call_out.vector;
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         gap_reg <= 8'hFF;
      else if (call)
         gap_reg <= 8'h00;
      else if (gap_reg != 8'hFF)
         gap_reg <= gap_reg + 8'h01;
   end
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_n_in);
   property p_pulse; call |=> !call; endproperty
   a_pulse: assert property (p_pulse)
      else $error("call pulse too long");
   property p_vec; call |-> vec[15:6] == 10'h000 && vec[2:0] == 3'h3; endproperty
   a_vec: assert property (p_vec)
      else $error("bad vector");
   property p_gap; call |-> gap_reg >= 8'h1D; endproperty
   a_gap: assert property (p_gap)
      else $error("calls too close");
   property p_cond;
      call |-> $past(cpu_last_cycle_in) && !$past(cpu_irq_block_in) && !$past(cpu_return_from_irq_in);
   endproperty
   a_cond: assert property (p_cond)
      else $error("call without conditions");
   property p_pre; call |-> ($past(isr) >> irq_call_out.level) == 4'h0; endproperty
   a_pre: assert property (p_pre)
      else $error("call not above service level");
   property p_set; call |-> isr[irq_call_out.level]; endproperty
   a_set: assert property (p_set)
      else $error("service bit not set");
   property p_ret;
      cpu_return_from_irq_in && isr != 4'h0 |=>
         $countones(isr) + 1 == $countones($past(isr)) && {isr, 1'b0} < {1'b0, $past(isr)};
   endproperty
   a_ret: assert property (p_ret)
      else $error("return did not clear top level");
   property p_hold; $changed(isr) |-> call || $past(cpu_return_from_irq_in); endproperty
   a_hold: assert property (p_hold)
      else $error("service bits changed alone");
   property p_rdw;
      hsel_in && htrans_in[1] && !hwrite_in && hready_in && ce_in |=>
         !hreadyout_out ##1 hreadyout_out;
   endproperty
   a_rdw: assert property (p_rdw)
      else $error("read wait state wrong");
   c_top: cover property (call && irq_call_out.level == 2'h3);
   c_nest: cover property (isr == 4'hE);
   c_ret: cover property (cpu_return_from_irq_in && isr != 4'h0);
endmodule : flvic_assertions

bind flvic_controller flvic_assertions u_chk (.ref_clk_in, .rst_n_in, .ce_in, .hsel_in,
   .htrans_in, .hwrite_in, .hready_in, .hreadyout_out, .cpu_last_cycle_in,
   .cpu_irq_block_in, .cpu_return_from_irq_in, .irq_call_out, .in_service_out);

// *** test/flvic_cpu_model.sv ***
`timescale 1ns/1ps
module flvic_cpu_model
   import flvic_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire flvic_call_t call_in,
   input  wire logic        stall_in,
   input  wire logic        block_in,
   input  wire logic        return_from_irq_in,
   output logic             last_cycle_out,
   output logic             block_out,
   output logic             return_from_irq_out
);
   logic [5:0] busy_reg;
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         busy_reg <= 6'h00;
      else if (call_in.call)
         busy_reg <= 6'h30;
      else if (busy_reg != 6'h00)
         busy_reg <= busy_reg - 6'h01;
   end
   assign last_cycle_out = !stall_in && busy_reg == 6'h00;
   assign block_out = block_in || return_from_irq_in;
   assign return_from_irq_out = return_from_irq_in;
endmodule : flvic_cpu_model

// *** test/tb.sv ***
`timescale 1ns/1ps
module tb;
   import flvic_pkg::*;
   logic        ref_clk_in, rst_n_in, hsel, hwrite, hready, hresp, stall, blk, return_from_irq;
   logic        rd_pend, last, cblk, creti;
   logic [1:0]  htrans;
   logic [3:0]  pins, isr;
   logic [31:0] haddr, hwdata, hrdata, seed;
   logic [31:0] exp_rd[$], exp_call[$];
   logic [7:0]  ra[4] = '{8'h04, 8'h08, 8'h14, 8'h18};
   logic [7:0]  fa[8] = '{8'h0C, 8'h0C, 8'h0C, 8'h0C, 8'h14, 8'h18, 8'h10, 8'h10};
   logic [7:0]  fe[8] = '{8'hAD, 8'h8D, 8'h85, 8'h05, 8'h03, 8'hC0, 8'h77, 8'h75};
   logic [7:0]  fc[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h75, 8'h55};
   flvic_evt_t  evt;
   flvic_call_t call_o;
   int          bad_count, samples_checked;
   flvic_controller DUT (.ref_clk_in, .rst_n_in, .ce_in(1'b1), .hsel_in(hsel),
      .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
      .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
      .hresp_out(hresp), .ext_irq_pin_n_in(pins), .periph_evt_in(evt),
      .cpu_last_cycle_in(last), .cpu_irq_block_in(cblk), .cpu_return_from_irq_in(creti),
      .irq_call_out(call_o), .in_service_out(isr));
   flvic_cpu_model cpu (.clk_in(ref_clk_in), .rst_n_in, .call_in(call_o), .stall_in(stall),
      .block_in(blk), .return_from_irq_in(return_from_irq), .last_cycle_out(last), .block_out(cblk),
      .return_from_irq_out(creti));
   initial
   begin
      ref_clk_in = 1'b0;
      forever #5 ref_clk_in = ~ref_clk_in;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : check
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : complete_run
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_in);
   endtask : cyc
   task automatic hold;
      int n;
      n = 0;
      do
      begin
         @(posedge ref_clk_in);
         n++;
      end
      while (hready !== 1'b1 && n < 50);
      if (hready !== 1'b1)
      begin
         bad_count++;
         complete_run();
      end
   endtask : hold
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr  <= {24'h000000, a};
      hold();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      hold();
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_rd.push_back({24'h000000, e});
      bus(1'b0, a, 32'h00000000);
   endtask : rd
   task automatic ex(input logic [15:0] v, input logic [1:0] l);
      exp_call.push_back({14'h0000, l, v});
   endtask : ex
   task automatic rt;
      return_from_irq <= 1'b1;
      cyc(1);
      return_from_irq <= 1'b0;
      cyc(1);
   endtask : rt
   task automatic pulse(input logic [5:0] v);
      evt <= flvic_evt_t'(v);
      cyc(1);
      evt <= flvic_evt_t'(6'h00);
      cyc(1);
   endtask : pulse
   task automatic drain;
      int n;
      n = 0;
      while (exp_call.size() + exp_rd.size() != 0 && n < 500)
      begin
         cyc(1);
         n++;
      end
      if (exp_call.size() + exp_rd.size() != 0)
      begin
         bad_count++;
         complete_run();
      end
   endtask : drain
   always @(posedge ref_clk_in)
   begin
      if (rd_pend && hready)
      begin
         check("read data", exp_rd.pop_front(), hrdata);
         check("response", 32'h0, 32'(hresp));
      end
      if (call_o.call === 1'b1)
         check("call", exp_call.size() != 0 ? exp_call.pop_front() : 32'hFFFFFFFF,
            {14'h0000, call_o.level, call_o.vector});
      if (!rst_n_in)
         rd_pend <= 1'b0;
      else if (hready)
         rd_pend <= hsel && htrans[1] && !hwrite;
   end
   initial
   begin
      #400000;
      bad_count++;
      complete_run();
   end
   initial
   begin
      {rst_n_in, hsel, hwrite, stall, blk, return_from_irq} = 6'h00;
      {htrans, haddr, hwdata} = 66'h0;
      pins = 4'hF;
      evt = flvic_evt_t'(6'h00);
      seed = 32'h00010370;
      cyc(4);
      rst_n_in <= 1'b1;
      cyc(1);
      for (int i = 0; i < 10; i++)
         rd(8'(i * 4), 8'h00);
      for (int i = 0; i < 8; i++)
      begin
         seed = xs(seed);
         wr(ra[i % 4], seed);
         rd(ra[i % 4], seed[7:0]);
      end
      wr(8'h20, seed);
      rd(8'h20, 8'h00);
      for (int i = 0; i < 4; i++)
         wr(ra[i], 32'h00000000);
      wr(8'h0C, 8'hAF);
      wr(8'h14, 8'h03);
      wr(8'h18, 8'hC0);
      wr(8'h10, 8'h77);
      for (int i = 0; i < 8; i++)
      begin
         ex(16'h0003 + 16'(i * 8), 2'h0);
         if (i == 0)
            wr(8'h00, 8'hBF);
         drain();
         rd(8'h20, 8'(i * 16 + 1));
         rd(fa[i], fe[i]);
         if (i > 3)
            wr(fa[i], fc[i]);
         rt();
      end
      wr(8'h04, 8'h14);
      wr(8'h08, 8'h12);
      wr(8'h00, 8'h9E);
      ex(16'h000B, 2'h1);
      pulse(6'h20);
      drain();
      ex(16'h0013, 2'h2);
      wr(8'h0C, 8'h0D);
      drain();
      wr(8'h0C, 8'h85);
      ex(16'h0023, 2'h3);
      wr(8'h14, 8'h01);
      drain();
      rd(8'h20, 8'h4E);
      check("in service", 32'hE, 32'(isr));
      wr(8'h14, 8'h00);
      rt();
      rt();
      ex(16'h001B, 2'h0);
      rt();
      drain();
      rt();
      wr(8'h04, 8'h00);
      wr(8'h08, 8'h00);
      wr(8'h0C, 8'h01);
      wr(8'h00, 8'h85);
      ex(16'h0003, 2'h0);
      pins <= 4'hE;
      cyc(24);
      pins <= 4'hF;
      drain();
      rt();
      ex(16'h0013, 2'h0);
      pins <= 4'hD;
      drain();
      rd(8'h0C, 8'h09);
      ex(16'h0013, 2'h0);
      rt();
      drain();
      pins <= 4'hF;
      cyc(24);
      rt();
      rd(8'h0C, 8'h01);
      wr(8'h00, 8'h08);
      pulse(6'h10);
      cyc(60);
      ex(16'h001B, 2'h0);
      blk <= 1'b1;
      wr(8'h00, 8'h88);
      cyc(60);
      check("pending calls", 32'h1, 32'(exp_call.size()));
      blk <= 1'b0;
      drain();
      rt();
      stall <= 1'b1;
      wr(8'h00, 8'hA0);
      wr(8'h18, 8'h40);
      cyc(36);
      wr(8'h18, 8'h00);
      cyc(12);
      stall <= 1'b0;
      cyc(60);
      wr(8'h1C, 8'h01);
      rd(8'h1C, 8'h01);
      ex(16'h002B, 2'h0);
      wr(8'h18, 8'h40);
      drain();
      wr(8'h18, 8'h00);
      rt();
      complete_run();
   end
endmodule : tb
